/* File: hdl/uart_baud_rate_generator.sv */
// Baud-rate tick generator for the serial port, with its control registers on AXI4-Lite.
// Assumes the transmit and receive shift logic consume one-cycle tick pulses on aclk.
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "baud_map.svh"

module uart_baud_rate_generator #(
	parameter int CD_W = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`AXI_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [`AXI_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic t1_event_pin,
	output logic tx_baud_tick,
	output logic rx_baud_tick
);

	localparam int CDIV_W = (1 << CD_W) - 1;

	generate
		if (CD_W < 1 || CD_W > 4) begin : bad_param
			$error("uart_baud_rate_generator: CD_W must be 1 to 4");
		end
	endgenerate

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	function automatic logic is_mapped(input logic [`AXI_ADDR_W-1:0] a);
		return a == `OFS_SERIAL || a == `OFS_POWER || a == `OFS_PLL || a == `OFS_TMODE || a == `OFS_T1CTL ||
			a == `OFS_T1CNT || a == `OFS_T2CTL || a == `OFS_T2RLD || a == `OFS_T2CNT || a == `OFS_FLAGS;
	endfunction : is_mapped

	// ****************************************
	// State
	// ****************************************
	logic awready_r, awready_nxt, wready_r, wready_nxt, bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt, wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic [`AXI_ADDR_W-1:0] awaddr_r, awaddr_nxt;
	logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
	logic [1:0] serial_r, serial_nxt, flags_r, flags_nxt;
	logic double_rate_select_r, double_rate_select_nxt, t1_run_r, t1_run_nxt;
	logic tx_sel_r, tx_sel_nxt, rx_sel_r, rx_sel_nxt, t2_run_r, t2_run_nxt;
	logic [CD_W-1:0] cd_r, cd_nxt;
	logic [3:0] timer_mode_reg_r, timer_mode_reg_nxt;
	logic [15:0] t1_cnt_r, t1_cnt_nxt, t2_rld_r, t2_rld_nxt;
	logic [CDIV_W-1:0] cdiv_r, cdiv_nxt;
	logic core_tick_r, core_tick_nxt;
	logic [3:0] mach_r, mach_nxt, t1_div_r, t1_div_nxt;
	logic [5:0] fix_r, fix_nxt;
	logic t1_half_r, t1_half_nxt;
	logic [2:0] pin_s_r, pin_s_nxt;
	logic pin_lvl_r, pin_lvl_nxt;
	logic tx_tick_r, tx_tick_nxt, rx_tick_r, rx_tick_nxt;

	logic [15:0] t2_count;
	logic t2_ovf, t2_tick;
	logic mach_tick, fix_tick, t1_ovf, t1_tick, t1_event, pin_fall;
	logic aw_fire, w_fire, ar_fire, do_write;
	logic [31:0] wr_word, t1_wr;
	logic [1:0] flag_set, flag_clr;
	baud_pkg::serial_mode_t smode;
	baud_pkg::t1_mode_t t1_mode;

	// ****************************************
	// Timer 2 in rate-generator use
	// ****************************************
	timer2_baud #(
		.CNT_W(16),
		.DIV_W(4)
	) u_timer2 (
		.aclk(aclk),
		.aresetn(aresetn),
		.core_tick(core_tick_r),
		.enable(t2_run_r & (tx_sel_r | rx_sel_r)),
		.reload(t2_rld_r),
		.count(t2_count),
		.overflow(t2_ovf),
		.baud_tick(t2_tick)
	);

	// ****************************************
	// Register bus
	// ****************************************
	always_comb begin
		aw_fire = awvalid & awready_r;
		w_fire = wvalid & wready_r;
		ar_fire = arvalid & arready_r;
		aw_held_nxt = aw_held_r | aw_fire;
		w_held_nxt = w_held_r | w_fire;
		awaddr_nxt = aw_fire ? awaddr : awaddr_r;
		wdata_nxt = w_fire ? wdata : wdata_r;
		wstrb_nxt = w_fire ? wstrb : wstrb_r;
		do_write = aw_held_r & w_held_r & ~bvalid_r;
		bvalid_nxt = bvalid_r & ~bready;
		bresp_nxt = bresp_r;
		wr_word = '0;
		serial_nxt = serial_r;
		double_rate_select_nxt = double_rate_select_r;
		cd_nxt = cd_r;
		timer_mode_reg_nxt = timer_mode_reg_r;
		t1_run_nxt = t1_run_r;
		tx_sel_nxt = tx_sel_r;
		rx_sel_nxt = rx_sel_r;
		t2_run_nxt = t2_run_r;
		t2_rld_nxt = t2_rld_r;
		flag_clr = '0;
		if (do_write) begin
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = is_mapped(awaddr_r) ? `RESP_OKAY : `RESP_SLVERR;
			unique case (awaddr_r)
				`OFS_SERIAL: begin
					wr_word = merge({30'h0, serial_r}, wdata_r, wstrb_r);
					serial_nxt = wr_word[`SER_MODE_HI:`SER_MODE_LO];
				end
				`OFS_POWER: begin
					wr_word = merge({24'h0, double_rate_select_r, 7'h0}, wdata_r, wstrb_r);
					double_rate_select_nxt = wr_word[`PWR_DOUBLE];
				end
				`OFS_PLL: begin
					wr_word = merge(32'(cd_r), wdata_r, wstrb_r);
					cd_nxt = wr_word[CD_W-1:0];
				end
				`OFS_TMODE: begin
					wr_word = merge({24'h0, timer_mode_reg_r, 4'h0}, wdata_r, wstrb_r);
					timer_mode_reg_nxt = wr_word[`TIMER_MODE_REG_T1_HI:`TIMER_MODE_REG_T1_LO];
				end
				`OFS_T1CTL: begin
					wr_word = merge({31'h0, t1_run_r}, wdata_r, wstrb_r);
					t1_run_nxt = wr_word[`T1CTL_RUN];
				end
				`OFS_T2CTL: begin
					wr_word = merge({26'h0, rx_sel_r, tx_sel_r, 1'b0, t2_run_r, 2'h0}, wdata_r, wstrb_r);
					rx_sel_nxt = wr_word[`T2CTL_RX];
					tx_sel_nxt = wr_word[`T2CTL_TX];
					t2_run_nxt = wr_word[`T2CTL_RUN];
				end
				`OFS_T2RLD: begin
					wr_word = merge({16'h0, t2_rld_r}, wdata_r, wstrb_r);
					t2_rld_nxt = wr_word[15:0];
				end
				`OFS_FLAGS: begin
					wr_word = merge(32'h0, wdata_r, wstrb_r);
					flag_clr = wr_word[`FLG_T2:`FLG_T1];
				end
				default: begin
				end
			endcase
		end
		awready_nxt = ~aw_held_nxt;
		wready_nxt = ~w_held_nxt;
		rvalid_nxt = rvalid_r & ~rready;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (ar_fire) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = is_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
			unique case (araddr)
				`OFS_SERIAL: rdata_nxt = {30'h0, serial_r};
				`OFS_POWER: rdata_nxt = {24'h0, double_rate_select_r, 7'h0};
				`OFS_PLL: rdata_nxt = 32'(cd_r);
				`OFS_TMODE: rdata_nxt = {24'h0, timer_mode_reg_r, 4'h0};
				`OFS_T1CTL: rdata_nxt = {31'h0, t1_run_r};
				`OFS_T1CNT: rdata_nxt = {16'h0, t1_cnt_r};
				`OFS_T2CTL: rdata_nxt = {26'h0, rx_sel_r, tx_sel_r, 1'b0, t2_run_r, 2'h0};
				`OFS_T2RLD: rdata_nxt = {16'h0, t2_rld_r};
				`OFS_T2CNT: rdata_nxt = {16'h0, t2_count};
				`OFS_FLAGS: rdata_nxt = {30'h0, flags_r};
				default: rdata_nxt = 32'h0;
			endcase
		end
		arready_nxt = ~rvalid_nxt;
	end

	// ****************************************
	// Core clock, machine cycle and fixed rate
	// ****************************************
	always_comb begin
		core_tick_nxt = cdiv_r >= CDIV_W'((1 << cd_r) - 1);
		cdiv_nxt = core_tick_nxt ? '0 : cdiv_r + 1'b1;
		mach_tick = core_tick_r && mach_r == `MACH_LAST;
		mach_nxt = mach_r;
		fix_tick = 1'b0;
		fix_nxt = fix_r;
		if (core_tick_r) begin
			mach_nxt = mach_tick ? '0 : mach_r + 1'b1;
			fix_tick = fix_r >= (double_rate_select_r ? `FIX_FAST_LAST : `FIX_SLOW_LAST);
			fix_nxt = fix_tick ? '0 : fix_r + 1'b1;
		end
	end

	// ****************************************
	// Timer 1 and its overflow divider
	// ****************************************
	always_comb begin
		pin_s_nxt = {pin_s_r[1:0], t1_event_pin};
		pin_lvl_nxt = (pin_s_r[1] == pin_s_r[2]) ? pin_s_r[2] : pin_lvl_r;
		pin_fall = pin_lvl_r & ~pin_lvl_nxt;
		t1_mode = baud_pkg::t1_mode_t'(timer_mode_reg_r[`TIMER_MODE_REG_MODE_HI:`TIMER_MODE_REG_MODE_LO]);
		t1_event = t1_run_r & (timer_mode_reg_r[`TIMER_MODE_REG_CT] ? pin_fall : mach_tick);
		t1_wr = merge({16'h0, t1_cnt_r}, wdata_r, wstrb_r);
		t1_cnt_nxt = t1_cnt_r;
		t1_ovf = 1'b0;
		if (t1_event) begin
			unique case (t1_mode)
				baud_pkg::T1_M13: begin
					t1_ovf = &t1_cnt_r[15:8] & &t1_cnt_r[4:0];
					t1_cnt_nxt = {t1_cnt_r[15:8] + 8'(&t1_cnt_r[4:0]), 3'h0, t1_cnt_r[4:0] + 5'h01};
				end
				baud_pkg::T1_M16: begin
					t1_ovf = &t1_cnt_r;
					t1_cnt_nxt = t1_cnt_r + 16'h0001;
				end
				baud_pkg::T1_M8R: begin
					t1_ovf = &t1_cnt_r[7:0];
					t1_cnt_nxt[7:0] = t1_ovf ? t1_cnt_r[15:8] : t1_cnt_r[7:0] + 8'h01;
				end
				baud_pkg::T1_STOP: begin
				end
			endcase
		end
		if (do_write && awaddr_r == `OFS_T1CNT) begin
			t1_cnt_nxt = t1_wr[15:0];
		end
		flag_set = {t2_ovf, t1_ovf};
		flags_nxt = (flags_r & ~flag_clr) | flag_set;
		t1_div_nxt = t1_div_r;
		t1_half_nxt = t1_half_r;
		t1_tick = 1'b0;
		if (t1_ovf) begin
			t1_div_nxt = t1_div_r + 1'b1;
			if (t1_div_r == `OVF16_LAST) begin
				t1_half_nxt = double_rate_select_r ? 1'b0 : ~t1_half_r;
				t1_tick = double_rate_select_r | t1_half_r;
			end
		end
	end

	// ****************************************
	// Tick selection per direction
	// ****************************************
	always_comb begin
		smode = baud_pkg::serial_mode_t'(serial_r);
		unique case (smode)
			baud_pkg::SER_SHIFT: begin
				tx_tick_nxt = mach_tick;
				rx_tick_nxt = mach_tick;
			end
			baud_pkg::SER_FIX9: begin
				tx_tick_nxt = fix_tick;
				rx_tick_nxt = fix_tick;
			end
			baud_pkg::SER_VAR8, baud_pkg::SER_VAR9: begin
				tx_tick_nxt = tx_sel_r ? t2_tick : t1_tick;
				rx_tick_nxt = rx_sel_r ? t2_tick : t1_tick;
			end
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= `RESP_OKAY;
			awaddr_r <= '0;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			serial_r <= `SERIAL_RST;
			double_rate_select_r <= 1'b0;
			cd_r <= CD_W'(`PLL_RST);
			timer_mode_reg_r <= `TIMER_MODE_REG_RST;
			t1_run_r <= 1'b0;
			t1_cnt_r <= `T1CNT_RST;
			tx_sel_r <= 1'b0;
			rx_sel_r <= 1'b0;
			t2_run_r <= 1'b0;
			t2_rld_r <= `T2RLD_RST;
			flags_r <= 2'h0;
			cdiv_r <= '0;
			core_tick_r <= 1'b0;
			mach_r <= 4'h0;
			fix_r <= 6'h00;
			t1_div_r <= 4'h0;
			t1_half_r <= 1'b0;
			pin_s_r <= 3'h7;
			pin_lvl_r <= 1'b1;
			tx_tick_r <= 1'b0;
			rx_tick_r <= 1'b0;
		end else begin
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			serial_r <= serial_nxt;
			double_rate_select_r <= double_rate_select_nxt;
			cd_r <= cd_nxt;
			timer_mode_reg_r <= timer_mode_reg_nxt;
			t1_run_r <= t1_run_nxt;
			t1_cnt_r <= t1_cnt_nxt;
			tx_sel_r <= tx_sel_nxt;
			rx_sel_r <= rx_sel_nxt;
			t2_run_r <= t2_run_nxt;
			t2_rld_r <= t2_rld_nxt;
			flags_r <= flags_nxt;
			cdiv_r <= cdiv_nxt;
			core_tick_r <= core_tick_nxt;
			mach_r <= mach_nxt;
			fix_r <= fix_nxt;
			t1_div_r <= t1_div_nxt;
			t1_half_r <= t1_half_nxt;
			pin_s_r <= pin_s_nxt;
			pin_lvl_r <= pin_lvl_nxt;
			tx_tick_r <= tx_tick_nxt;
			rx_tick_r <= rx_tick_nxt;
		end
	end

	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign tx_baud_tick = tx_tick_r;
	assign rx_baud_tick = rx_tick_r;

endmodule : uart_baud_rate_generator

/* File: hdl/baud_map.svh */
// Register map, field positions, reset values and divide counts of the baud-rate generator.
// Assumes byte addressing on an AXI4-Lite bus, one 32-bit word per register.
`ifndef BAUD_MAP_SVH
`define BAUD_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define AXI_ADDR_W 8
`define OFS_SERIAL 8'h00
`define OFS_POWER 8'h04
`define OFS_PLL 8'h08
`define OFS_TMODE 8'h0C
`define OFS_T1CTL 8'h10
`define OFS_T1CNT 8'h14
`define OFS_T2CTL 8'h18
`define OFS_T2RLD 8'h1C
`define OFS_T2CNT 8'h20
`define OFS_FLAGS 8'h24

// ****************************************
// Field positions
// ****************************************
`define SER_MODE_HI 1
`define SER_MODE_LO 0
`define PWR_DOUBLE 7
`define PLL_CD_HI 2
`define PLL_CD_LO 0
`define TIMER_MODE_REG_T1_HI 7
`define TIMER_MODE_REG_T1_LO 4
`define TIMER_MODE_REG_MODE_HI 2
`define TIMER_MODE_REG_MODE_LO 1
`define TIMER_MODE_REG_CT 0
`define T1CTL_RUN 0
`define T2CTL_RX 5
`define T2CTL_TX 4
`define T2CTL_RUN 2
`define FLG_T1 0
`define FLG_T2 1

// ****************************************
// Reset values
// ****************************************
`define SERIAL_RST 2'h0
`define PLL_RST 3'h0
`define TIMER_MODE_REG_RST 4'h0
`define T1CNT_RST 16'h0000
`define T2RLD_RST 16'h0000

// ****************************************
// Divide counts (terminal values) and bus response codes
// ****************************************
`define MACH_LAST 4'hB
`define OVF16_LAST 4'hF
`define FIX_SLOW_LAST 6'h3F
`define FIX_FAST_LAST 6'h1F
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: hdl/baud_pkg.sv */
// Types shared by the baud-rate generator files.
// Assumes the companion map header for all numeric constants.
package baud_pkg;

	// ****************************************
	// Serial mode and timer 1 mode encodings
	// ****************************************
	typedef enum logic [1:0] {
		SER_SHIFT = 2'b00,
		SER_VAR8 = 2'b01,
		SER_FIX9 = 2'b10,
		SER_VAR9 = 2'b11
	} serial_mode_t;

	typedef enum logic [1:0] {
		T1_M13 = 2'b00,
		T1_M16 = 2'b01,
		T1_M8R = 2'b10,
		T1_STOP = 2'b11
	} t1_mode_t;

endpackage : baud_pkg

/* File: hdl/timer2_baud.sv */
// Timer 2 in rate-generator operation: count, 16-bit auto-reload, divide of overflows.
// Assumes core_tick is a one-cycle pulse per core clock period on aclk.
`timescale 1ns/1ps

module timer2_baud #(
	parameter int CNT_W = 16,
	parameter int DIV_W = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic core_tick,
	input wire logic enable,
	input wire logic [CNT_W-1:0] reload,
	output logic [CNT_W-1:0] count,
	output logic overflow,
	output logic baud_tick
);

	generate
		if (CNT_W < 2 || DIV_W < 1) begin : bad_param
			$error("timer2_baud: widths too small");
		end
	endgenerate

	logic half_r, half_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [DIV_W-1:0] div_r, div_nxt;
	logic ovf_r, ovf_nxt;
	logic tick_r, tick_nxt;

	// ****************************************
	// Count logic
	// ****************************************
	always_comb begin
		half_nxt = half_r;
		cnt_nxt = cnt_r;
		div_nxt = div_r;
		ovf_nxt = 1'b0;
		tick_nxt = 1'b0;
		if (!enable) begin
			half_nxt = 1'b0;
			cnt_nxt = reload;
			div_nxt = '0;
		end else if (core_tick) begin
			half_nxt = ~half_r;
			if (half_r) begin
				if (&cnt_r) begin
					cnt_nxt = reload;
					ovf_nxt = 1'b1;
					div_nxt = div_r + 1'b1;
					tick_nxt = &div_r;
				end else begin
					cnt_nxt = cnt_r + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			half_r <= 1'b0;
			cnt_r <= '0;
			div_r <= '0;
			ovf_r <= 1'b0;
			tick_r <= 1'b0;
		end else begin
			half_r <= half_nxt;
			cnt_r <= cnt_nxt;
			div_r <= div_nxt;
			ovf_r <= ovf_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign count = cnt_r;
	assign overflow = ovf_r;
	assign baud_tick = tick_r;

endmodule : timer2_baud

/* File: tb/baud_chk.sv */
// Checker of the baud generator ports: bus handshakes and tick pulses.
// Assumes it is bound into every uart_baud_rate_generator instance.
`timescale 1ns/1ps
`include "baud_map.svh"
module baud_chk #(
	parameter int CD_W = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic tx_baud_tick,
	input wire logic rx_baud_tick
);
	// Tick spacing is judged only once the last register write is well past
	logic [4:0] wr_age;
	logic [3:0] tx_age, rx_age;
	always_ff @(posedge aclk) begin
		if (!aresetn || bvalid) begin
			wr_age <= 5'h00;
		end else if (wr_age != 5'h1F) begin
			wr_age <= wr_age + 5'h01;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || tx_baud_tick) begin
			tx_age <= 4'h0;
		end else if (tx_age != 4'hF) begin
			tx_age <= tx_age + 4'h1;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || rx_baud_tick) begin
			rx_age <= 4'h0;
		end else if (rx_age != 4'hF) begin
			rx_age <= rx_age + 4'h1;
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_tx_gap;
		tx_baud_tick && wr_age == 5'h1F |-> tx_age >= 4'h8;
	endproperty
	a_tx_gap: assert property (p_tx_gap) else $error("tx tick spacing too short");
	property p_rx_gap;
		rx_baud_tick && wr_age == 5'h1F |-> rx_age >= 4'h8;
	endproperty
	a_rx_gap: assert property (p_rx_gap) else $error("rx tick spacing too short");
	property p_b_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read response dropped early");
	property p_b_answer;
		awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
	endproperty
	a_b_answer: assert property (p_b_answer) else $error("write response missing");
	property p_r_answer;
		arvalid && arready |-> ##[1:2] rvalid;
	endproperty
	a_r_answer: assert property (p_r_answer) else $error("read response missing");
	property p_ar_block;
		rvalid |-> !arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read accepted while answer pending");
	property p_b_clear;
		bvalid && bready |=> !bvalid;
	endproperty
	a_b_clear: assert property (p_b_clear) else $error("write response repeated");
	property p_unmapped;
		arvalid && arready && araddr == 8'hFC |-> ##[1:2] (rvalid && rresp == `RESP_SLVERR && rdata == 32'h0);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
	property p_mapped;
		arvalid && arready && araddr == `OFS_SERIAL |-> ##[1:2] (rvalid && rresp == `RESP_OKAY);
	endproperty
	a_mapped: assert property (p_mapped) else $error("mapped read refused");
endmodule : baud_chk

bind uart_baud_rate_generator baud_chk #(.CD_W(CD_W)) baud_chk_i (.*);

/* File: tb/uart_shift_model.sv */
// Shift-logic stand-in: consumes tick pulses and measures their spacing.
// Assumes ticks are one-cycle pulses on aclk.
`timescale 1ns/1ps
module uart_shift_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tx_baud_tick,
	input wire logic rx_baud_tick,
	output logic [31:0] tx_per,
	output logic [31:0] rx_per,
	output logic [31:0] tx_cnt,
	output logic [31:0] rx_cnt
);
	logic [31:0] tx_age, rx_age;
	always @(posedge aclk) begin
		if (!aresetn) begin
			{tx_per, rx_per, tx_cnt, rx_cnt, tx_age, rx_age} <= '0;
		end else begin
			tx_age <= tx_age + 32'h1;
			rx_age <= rx_age + 32'h1;
			if (tx_baud_tick) begin
				tx_per <= tx_age + 32'h1;
				tx_age <= 32'h0;
				tx_cnt <= tx_cnt + 32'h1;
			end
			if (rx_baud_tick) begin
				rx_per <= rx_age + 32'h1;
				rx_age <= 32'h0;
				rx_cnt <= rx_cnt + 32'h1;
			end
		end
	end
endmodule : uart_shift_model

/* File: tb/tb.sv */
// Self-checking bench of the baud generator: register access and tick spacing per mode.
// Assumes the shift model beside the design and the bound checker.
`timescale 1ns/1ps
`include "baud_map.svh"
module tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic t1_event_pin = 1'b1, pin_run = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, tx_baud_tick, rx_baud_tick;
	logic [1:0] bresp, rresp, pin_div = 2'h0;
	logic [31:0] rdata, tx_per, rx_per, tx_cnt, rx_cnt;
	int n_mismatch = 0, checks = 0;
	uart_baud_rate_generator uart_baud_rate_generator_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .t1_event_pin(t1_event_pin),
		.tx_baud_tick(tx_baud_tick), .rx_baud_tick(rx_baud_tick));
	uart_shift_model uart_shift_model_i (.aclk(aclk), .aresetn(aresetn), .tx_baud_tick(tx_baud_tick),
		.rx_baud_tick(rx_baud_tick), .tx_per(tx_per), .rx_per(rx_per), .tx_cnt(tx_cnt), .rx_cnt(rx_cnt));
	initial begin
		forever #2 aclk = ~aclk;
	end
	// External events: one falling edge every 8 cycles
	always @(posedge aclk) begin
		if (pin_run) begin
			pin_div <= pin_div + 2'h1;
			if (pin_div == 2'h3)
				t1_event_pin <= !t1_event_pin;
		end
	end
	// ****************************************
	// Bus and compare tasks
	// ****************************************
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic cmp_per(input logic [31:0] exp_tx, input logic [31:0] exp_rx);
		int t;
		logic [31:0] s_tx, s_rx;
		s_tx = tx_cnt;
		s_rx = rx_cnt;
		t = 0;
		while ((tx_cnt < s_tx + 32'h3 || rx_cnt < s_rx + 32'h3) && t < 6000) begin
			@(posedge aclk);
			t++;
		end
		cmp({31'h0, t < 6000}, 32'h1);
		cmp(tx_per, exp_tx);
		cmp(rx_per, exp_rx);
	endtask : cmp_per
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok, w_ok;
		@(posedge aclk);
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (!bvalid)
			@(posedge aclk);
		r = bresp;
		bready <= 1'b0;
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(posedge aclk);
		while (!arready);
		arvalid <= 1'b0;
		while (!rvalid)
			@(posedge aclk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_read
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_write(a, d, r);
		cmp({30'h0, r}, {30'h0, `RESP_OKAY});
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		axi_read(a, d, r);
		cmp(d, exp);
		cmp({30'h0, r}, {30'h0, `RESP_OKAY});
	endtask : rd_chk
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		rd_chk(`OFS_SERIAL, 32'h0);
		rd_chk(`OFS_PLL, 32'h0);
		rd_chk(`OFS_T2RLD, 32'h0);
		cmp_per(32'hC, 32'hC);
		wr(`OFS_T2RLD, 32'h0000FFFF);
		rd_chk(`OFS_T2RLD, 32'h0000FFFF);
		wr(`OFS_T2CNT, 32'h00001234);
		rd_chk(`OFS_T2CNT, 32'h0000FFFF);
		axi_read(8'hFC, d, r);
		cmp(d, 32'h0);
		cmp({30'h0, r}, {30'h0, `RESP_SLVERR});
		axi_write(8'hFC, 32'hFFFFFFFF, r);
		cmp({30'h0, r}, {30'h0, `RESP_SLVERR});
		$display("test regs done");
	endtask : t_regs
	task automatic t_fixed;
		wr(`OFS_SERIAL, 32'h2);
		cmp_per(32'h40, 32'h40);
		wr(`OFS_POWER, 32'h80);
		cmp_per(32'h20, 32'h20);
		wr(`OFS_PLL, 32'h1);
		cmp_per(32'h40, 32'h40);
		wr(`OFS_PLL, 32'h0);
		$display("test fixed done");
	endtask : t_fixed
	task automatic t_timer2;
		wr(`OFS_SERIAL, 32'h1);
		wr(`OFS_T2CTL, 32'h34);
		cmp_per(32'h20, 32'h20);
		wr(`OFS_T2RLD, 32'h0000FFFE);
		cmp_per(32'h40, 32'h40);
		wr(`OFS_T2RLD, 32'h0000FFFF);
		$display("test timer2 done");
	endtask : t_timer2
	task automatic t_timer1;
		wr(`OFS_SERIAL, 32'h3);
		wr(`OFS_T2CTL, 32'h0);
		// Overflow flag left unserviced while timer 1 sets the rate
		wr(`OFS_TMODE, 32'h40);
		wr(`OFS_T1CNT, 32'h0000FFFF);
		wr(`OFS_T1CTL, 32'h1);
		cmp_per(32'hC0, 32'hC0);
		rd_chk(`OFS_FLAGS, 32'h3);
		wr(`OFS_POWER, 32'h0);
		cmp_per(32'h180, 32'h180);
		wr(`OFS_T2CTL, 32'h14);
		cmp_per(32'h20, 32'h180);
		$display("test timer1 done");
	endtask : t_timer1
	task automatic t_counter;
		wr(`OFS_T2CTL, 32'h0);
		wr(`OFS_POWER, 32'h80);
		wr(`OFS_TMODE, 32'h50);
		pin_run <= 1'b1;
		cmp_per(32'h80, 32'h80);
		pin_run <= 1'b0;
		$display("test counter done");
	endtask : t_counter
	task automatic t_soft;
		logic [31:0] d, s;
		logic [1:0] r;
		wr(`OFS_T1CNT, 32'h0000FFF0);
		wr(`OFS_FLAGS, 32'h3);
		rd_chk(`OFS_FLAGS, 32'h0);
		wr(`OFS_TMODE, 32'h20);
		s = tx_cnt;
		repeat (32) begin
			d = 32'h0;
			while (!d[0])
				axi_read(`OFS_FLAGS, d, r);
			wr(`OFS_FLAGS, 32'h1);
			wr(`OFS_T1CNT, 32'h0000FFF0);
		end
		cmp(tx_cnt - s, 32'h2);
		wr(`OFS_TMODE, 32'h60);
		axi_read(`OFS_T1CNT, d, r);
		repeat (50) @(posedge aclk);
		rd_chk(`OFS_T1CNT, d);
		$display("test soft reload done");
	endtask : t_soft
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report
	initial begin
		#(4 * 60000);
		n_mismatch++;
		final_report();
	end
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_fixed();
		t_timer2();
		t_timer1();
		t_counter();
		t_soft();
		final_report();
	end
endmodule : tb
